// ---- design/hfc_pkg.sv ----
// package for the half/single float convert unit
package hfc_pkg;
    // immediate byte fields
    localparam int IMM_RC_LSB    = 0;
    localparam int IMM_SRC_BIT   = 2;
    // rounding modes
    typedef enum logic [1:0] {
        HFC_RND_NEAR  = 2'b00,
        HFC_RND_DOWN  = 2'b01,
        HFC_RND_UP    = 2'b10,
        HFC_RND_TRUNC = 2'b11
    } hfc_round_type;
    // operation codes
    typedef enum logic [1:0] {
        HFC_OP_NONE  = 2'b00,
        HFC_OP_H2S   = 2'b01,
        HFC_OP_S2H   = 2'b10,
        HFC_OP_XREAD = 2'b11
    } hfc_op_type;
    // control bit positions
    localparam int XEN_SSE_BIT   = 1;
    localparam int XEN_VEC_BIT   = 2;
    localparam int CR4_HND_BIT   = 10;
    // feature-query leaf 1 ecx bit positions
    localparam int FQ_CLMUL_BIT  = 1;
    localparam int FQ_CIPHER_BIT = 25;
    localparam int FQ_OSXS_BIT   = 27;
    localparam int FQ_VEC_BIT    = 28;
    // NaN narrowing
    localparam int NAN_DROP_BITS = 14;
    localparam logic [7:0] S_EXP_ONES = 8'hff;
    localparam logic [4:0] H_EXP_ONES = 5'h1f;
    // flags vector layout
    localparam int FLG_INV = 0;
    localparam int FLG_DEN = 1;
    localparam int FLG_W   = 2;
    // reset values
    localparam logic [63:0] XEN_RST   = 64'h0000_0000_0000_0001;
    localparam logic [1:0]  FLG_RST   = 2'h0;
    // register offsets on the local apb slave
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_MASK  = 8'h08;
    localparam logic [7:0] OFS_XENLO = 8'h0c;
    localparam logic [7:0] OFS_FEAT  = 8'h10;
endpackage : hfc_pkg

// ---- design/hfc_lane.sv ----
// one packed lane: single<->half conversion with NaN and denormal handling
`timescale 1ns/10ps
module hfc_lane (
    // operation
    input  wire logic        to_half,
    input  wire logic [1:0]  rnd,
    // operands
    input  wire logic [31:0] src_s,
    input  wire logic [15:0] src_h,
    // results
    output logic      [31:0] res_s,
    output logic      [15:0] res_h,
    output logic             nan_in,
    output logic             snan_in,
    output logic             den_in
);
    import hfc_pkg::*;

    logic        sgn;
    logic [7:0]  e8;
    logic [22:0] m23;
    logic [4:0]  e5;
    logic [9:0]  m10;
    logic [24:0] sig;
    logic [9:0]  hm;
    logic [4:0]  he;
    logic        grd;
    logic        stk;
    logic        inc;
    logic [4:0]  lz;
    logic [9:0]  nm;
    integer      sh;

    always_comb begin
        sgn = to_half ? src_s[31] : src_h[15];
        e8 = src_s[30:23];
        m23 = src_s[22:0];
        e5 = src_h[14:10];
        m10 = src_h[9:0];
        res_s = 32'h0;
        res_h = 16'h0;
        nan_in = 1'b0;
        snan_in = 1'b0;
        den_in = 1'b0;
        sig = 25'h0;
        hm = 10'h0;
        he = 5'h0;
        grd = 1'b0;
        stk = 1'b0;
        inc = 1'b0;
        lz = 5'h0;
        nm = 10'h0;
        sh = 0;
        if (to_half) begin
            den_in = (e8 == 8'h00) && (m23 != 23'h0);
            if (e8 == S_EXP_ONES && m23 != 23'h0) begin
                nan_in = 1'b1;
                snan_in = ~m23[22];
                // keep sign, top bits of significand; force quiet
                res_h = {sgn, H_EXP_ONES, m23[22:NAN_DROP_BITS-1] | 10'h200};
            end else if (e8 == S_EXP_ONES) begin
                res_h = {sgn, H_EXP_ONES, 10'h0};
            end else if (e8 > 8'd142) begin
                // beyond range: saturate per rounding direction
                if (rnd == HFC_RND_TRUNC || (rnd == HFC_RND_DOWN && !sgn) || (rnd == HFC_RND_UP && sgn))
                    res_h = {sgn, 15'h7bff};
                else
                    res_h = {sgn, H_EXP_ONES, 10'h0};
            end else begin
                // align to half grid; denormal half outputs shift further right
                sig = {1'b0, e8 != 8'h00, m23} ;
                if (e8 >= 8'd113) begin
                    he = 5'(e8 - 8'd112);
                    hm = m23[22:13];
                    grd = m23[12];
                    stk = |m23[11:0];
                end else begin
                    sh = 113 - int'(e8);
                    if (sh > 24) sh = 25;
                    sig = sig >> sh;
                    he = 5'h0;
                    hm = sig[22:13];
                    grd = sig[12];
                    stk = (|sig[11:0]) || (e8 != 8'h00 && sh > 0 &&
                          ((({1'b1, m23}) & ((24'h1 << sh) - 24'h1)) != 24'h0)) || (e8 == 8'h00 && m23 != 23'h0);
                end
                unique case (rnd)
                    HFC_RND_NEAR:  inc = grd && (stk || hm[0]);
                    HFC_RND_DOWN:  inc = sgn && (grd || stk);
                    HFC_RND_UP:    inc = !sgn && (grd || stk);
                    HFC_RND_TRUNC: inc = 1'b0;
                endcase
                res_h = {sgn, he, hm} + {15'h0, inc};
            end
        end else begin
            if (e5 == H_EXP_ONES && m10 != 10'h0) begin
                nan_in = 1'b1;
                snan_in = ~m10[9];
                res_s = {sgn, S_EXP_ONES, m10 | 10'h200, 13'h0};
            end else if (e5 == H_EXP_ONES) begin
                res_s = {sgn, S_EXP_ONES, 23'h0};
            end else if (e5 == 5'h0 && m10 == 10'h0) begin
                res_s = {sgn, 31'h0};
            end else if (e5 == 5'h0) begin
                // normalise the half denormal; flag left alone
                lz = 5'h0;
                for (int i = 9; i >= 0; i--) begin
                    if (m10[i] && lz == 5'h0) lz = 5'(10 - i);
                end
                nm = 10'(m10 << lz);
                res_s = {sgn, 8'(8'd113 - {3'h0, lz}), nm, 13'h0};
            end else begin
                res_s = {sgn, 8'({3'h0, e5} + 8'd112), m10, 13'h0};
            end
        end
    end
endmodule : hfc_lane

// ---- design/hfc_convert_unit.sv ----
// half/single float convert unit with extended-state gating and feature report
// Functional notes
// - with the override bit clear, immediate bits 1:0 pick nearest-even, down, up or truncate; bits 7:3 ignored.
// - immediate bit 2 at 0 uses the immediate field, at 1 uses the global rounding control.
// - a single NaN narrows to half keeping sign, all-ones exponent and the top 10 fraction bits.
// - a signalling NaN input has the second significand bit forced to 1 giving a quiet result.
// - a signalling NaN raises invalid when unmasked, else gives the quiet NaN; quiet NaN is no exception.
// - single-to-half of a denormal source sets the denormal flag and, with the denormal mask set, writes the rounded result.
// - half-to-single of a denormal source leaves the denormal flag and gives the same result.
// - every vector instruction faults undefined unless enable bits 2 and 1 are both set.
// - leaf 1 ecx reports bit 27 os state access, 28 vector, 25 cipher, 1 carry-less multiply.
// - the coprocessor-emulation bit never traps vector instructions.
// - unmasked conversion exceptions deliver the simd fault only when control bit 10 is set.
// - with that bit clear an unmasked exception becomes an undefined-opcode fault.
// - the extended-control read with ecx 0 returns the enable register in edx:eax while the os flag is set, else faults undefined.
// - the extended-control write is taken only at privileged level; the os flag implies the state support.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module hfc_convert_unit #(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    // instruction issue
    input  wire logic                 op_valid,
    input  wire hfc_pkg::hfc_op_type  op_code,
    input  wire logic [7:0]           op_imm,
    input  wire logic [31:0]          op_ecx,
    input  wire logic [LANES*32-1:0]  src_single,
    input  wire logic [LANES*16-1:0]  src_half,
    // extended-control write
    input  wire logic                 xwr_valid,
    input  wire logic                 xwr_priv,
    input  wire logic [31:0]          xwr_ecx,
    input  wire logic [63:0]          xwr_data,
    // os control state and feature straps
    input  wire logic [1:0]           global_round_control,
    input  wire logic                 inv_mask,
    input  wire logic                 den_mask,
    input  wire logic                 simd_handler_present,
    input  wire logic                 coproc_emulation_bit,
    input  wire logic                 os_ext_state_flag,
    input  wire logic                 vec_supported,
    input  wire logic                 cipher_supported,
    input  wire logic                 clmul_supported,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // results
    output logic                      res_valid,
    output logic [LANES*32-1:0]       res_single,
    output logic [LANES*16-1:0]       res_half,
    output logic [63:0]               res_edx_eax,
    output logic                      undefined_opcode_fault,
    output logic                      simd_fp_fault,
    output logic                      xwr_fault,
    output logic [31:0]               feature_ecx,
    output logic                      irq
);
    import hfc_pkg::*;

    logic [63:0]           ext_state_enable_reg_r, ext_state_enable_reg_nxt;
    logic [FLG_W-1:0]      flags_r, flags_nxt;
    logic [FLG_W-1:0]      irq_mask_r, irq_mask_nxt;
    logic                  res_valid_r, res_valid_nxt;
    logic [LANES*32-1:0]   res_single_r, res_single_nxt;
    logic [LANES*16-1:0]   res_half_r, res_half_nxt;
    logic [63:0]           res_x_r, res_x_nxt;
    logic                  ud_r, ud_nxt;
    logic                  xm_r, xm_nxt;
    logic                  xwf_r, xwf_nxt;
    logic [31:0]           feat_r, feat_nxt;
    logic [31:0]           prdata_r, prdata_nxt;
    logic                  pready_r, pready_nxt;
    logic                  pslverr_r, pslverr_nxt;
    logic                  irq_r, irq_nxt;

    logic [1:0]            eff_rnd;
    logic [LANES*32-1:0]   lane_s;
    logic [LANES*16-1:0]   lane_h;
    logic [LANES-1:0]      lane_nan, lane_snan, lane_den;
    logic                  is_vec, vec_ok, ev_inv, ev_den, unmasked;

    function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [FLG_W-1:0] st,
                                           input logic [FLG_W-1:0] mk, input logic [63:0] xe,
                                           input logic [31:0] ft);
        rd_mux = 32'h0;
        unique case (a)
            OFS_STAT:  rd_mux = {30'h0, st};
            OFS_MASK:  rd_mux = {30'h0, mk};
            OFS_XENLO: rd_mux = xe[31:0];
            OFS_FEAT:  rd_mux = ft;
            default:   rd_mux = 32'h0;
        endcase
    endfunction : rd_mux

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_MASK) ||
                  (a == OFS_XENLO) || (a == OFS_FEAT);
    endfunction : addr_ok

    // override bit picks immediate field or global control
    assign eff_rnd = op_imm[IMM_SRC_BIT] ? global_round_control : op_imm[IMM_RC_LSB +: 2];

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            hfc_lane u_lane (
                .to_half (op_code == HFC_OP_S2H),
                .rnd     (eff_rnd),
                .src_s   (src_single[g*32 +: 32]),
                .src_h   (src_half[g*16 +: 16]),
                .res_s   (lane_s[g*32 +: 32]),
                .res_h   (lane_h[g*16 +: 16]),
                .nan_in  (lane_nan[g]),
                .snan_in (lane_snan[g]),
                .den_in  (lane_den[g])
            );
        end
    endgenerate

    always_comb begin
        is_vec = op_valid && (op_code == HFC_OP_H2S || op_code == HFC_OP_S2H);
        // emulation bit deliberately not consulted here
        vec_ok = ext_state_enable_reg_r[XEN_VEC_BIT] && ext_state_enable_reg_r[XEN_SSE_BIT];
        ev_inv = is_vec && vec_ok && (|lane_snan);
        ev_den = is_vec && vec_ok && (op_code == HFC_OP_S2H) && (|lane_den);
        unmasked = (ev_inv && !inv_mask) || (ev_den && !den_mask);

        ext_state_enable_reg_nxt = ext_state_enable_reg_r;
        xwf_nxt = 1'b0;
        if (xwr_valid) begin
            // only privileged writes to index 0 with bit 0 kept land
            if (xwr_priv && xwr_ecx == 32'h0 && xwr_data[0]) begin
                ext_state_enable_reg_nxt = xwr_data;
            end else begin
                xwf_nxt = 1'b1;
            end
        end

        res_valid_nxt = op_valid;
        res_single_nxt = res_single_r;
        res_half_nxt = res_half_r;
        res_x_nxt = res_x_r;
        ud_nxt = 1'b0;
        xm_nxt = 1'b0;
        if (is_vec && !vec_ok) begin
            ud_nxt = 1'b1;
        end else if (is_vec && unmasked) begin
            // without an os handler the fault degrades to undefined opcode
            xm_nxt = simd_handler_present;
            ud_nxt = !simd_handler_present;
        end else if (is_vec) begin
            res_single_nxt = lane_s;
            res_half_nxt = lane_h;
        end else if (op_valid && op_code == HFC_OP_XREAD) begin
            if (op_ecx == 32'h0 && os_ext_state_flag) res_x_nxt = ext_state_enable_reg_r;
            else ud_nxt = 1'b1;
        end

        feat_nxt = 32'h0;
        feat_nxt[FQ_OSXS_BIT] = os_ext_state_flag;
        feat_nxt[FQ_VEC_BIT] = vec_supported;
        feat_nxt[FQ_CIPHER_BIT] = cipher_supported;
        feat_nxt[FQ_CLMUL_BIT] = clmul_supported;

        // sticky status: set wins over write-one clear
        flags_nxt = flags_r;
        irq_mask_nxt = irq_mask_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            pready_nxt = 1'b1;
            pslverr_nxt = !addr_ok(paddr);
            prdata_nxt = pwrite ? 32'h0 : rd_mux(paddr, flags_r, irq_mask_r, ext_state_enable_reg_r, feat_r);
        end
        if (psel && penable && pready_r && pwrite) begin
            if (paddr == OFS_STAT) flags_nxt = flags_r & ~pwdata[FLG_W-1:0];
            if (paddr == OFS_MASK) irq_mask_nxt = pwdata[FLG_W-1:0];
        end
        if (ev_inv) flags_nxt[FLG_INV] = 1'b1;
        if (ev_den) flags_nxt[FLG_DEN] = 1'b1;
        irq_nxt = |(flags_nxt & irq_mask_nxt);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_state_enable_reg_r <= XEN_RST;
            flags_r <= FLG_RST;
            irq_mask_r <= FLG_RST;
            res_valid_r <= 1'b0;
            res_single_r <= '0;
            res_half_r <= '0;
            res_x_r <= 64'h0;
            ud_r <= 1'b0;
            xm_r <= 1'b0;
            xwf_r <= 1'b0;
            feat_r <= 32'h0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ext_state_enable_reg_r <= ext_state_enable_reg_nxt;
            flags_r <= flags_nxt;
            irq_mask_r <= irq_mask_nxt;
            res_valid_r <= res_valid_nxt;
            res_single_r <= res_single_nxt;
            res_half_r <= res_half_nxt;
            res_x_r <= res_x_nxt;
            ud_r <= ud_nxt;
            xm_r <= xm_nxt;
            xwf_r <= xwf_nxt;
            feat_r <= feat_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign res_valid = res_valid_r;
    assign res_single = res_single_r;
    assign res_half = res_half_r;
    assign res_edx_eax = res_x_r;
    assign undefined_opcode_fault = ud_r;
    assign simd_fp_fault = xm_r;
    assign xwr_fault = xwf_r;
    assign feature_ecx = feat_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
endmodule : hfc_convert_unit

// ---- test/hfc_convert_asserts.sv ----
// assertion checker for the half/single convert unit
`timescale 1ns/10ps
module hfc_convert_chk #(
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic                mclk,
    input wire logic                sys_rst,
    // issue and control
    input wire logic                op_valid,
    input wire hfc_pkg::hfc_op_type op_code,
    input wire logic [31:0]         op_ecx,
    input wire logic                xwr_valid,
    input wire logic                xwr_priv,
    input wire logic                simd_handler_present,
    input wire logic                os_ext_state_flag,
    input wire logic                vec_supported,
    input wire logic                cipher_supported,
    input wire logic                clmul_supported,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    // results
    input wire logic                res_valid,
    input wire logic [LANES*16-1:0] res_half,
    input wire logic                undefined_opcode_fault,
    input wire logic                simd_fp_fault,
    input wire logic                xwr_fault,
    input wire logic [31:0]         feature_ecx
);
    import hfc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    res_pulse_a: assert property (op_valid |=> res_valid)
        else $error("no result one cycle after issue");
    fault_excl_a: assert property (!(undefined_opcode_fault && simd_fp_fault))
        else $error("both faults at once");
    simd_gate_a: assert property (simd_fp_fault |-> $past(simd_handler_present))
        else $error("simd fault without handler");
    fault_cause_a: assert property (undefined_opcode_fault |-> $past(op_valid))
        else $error("fault without an issued op");
    xread_index_a: assert property (op_valid && op_code == HFC_OP_XREAD && op_ecx != 32'h0
        |=> undefined_opcode_fault) else $error("bad read index not refused");
    xwr_priv_a: assert property (xwr_valid && !xwr_priv |=> xwr_fault)
        else $error("unprivileged write not refused");
    feat_track_a: assert property (!$past(sys_rst) |->
        {feature_ecx[28], feature_ecx[27], feature_ecx[25], feature_ecx[1]} ==
        $past({vec_supported, os_ext_state_flag, cipher_supported, clmul_supported}))
        else $error("feature bits wrong");
    res_hold_a: assert property ($changed(res_half) && !$past(sys_rst) |->
        res_valid && !undefined_opcode_fault && !simd_fp_fault) else $error("result moved without success");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");

    cover property (simd_fp_fault);
    cover property (xwr_fault);
    cover property (res_valid && !undefined_opcode_fault && !simd_fp_fault);
endmodule : hfc_convert_chk

bind hfc_convert_unit hfc_convert_chk #(.LANES(LANES)) hfc_convert_chk_i (
    .mclk, .sys_rst, .op_valid, .op_code, .op_ecx, .xwr_valid, .xwr_priv, .simd_handler_present,
    .os_ext_state_flag, .vec_supported, .cipher_supported, .clmul_supported, .psel, .penable,
    .pready, .res_valid, .res_half, .undefined_opcode_fault, .simd_fp_fault, .xwr_fault, .feature_ecx
);

// ---- test/hfc_os_model.sv ----
// model of the os control state and feature straps feeding the unit
`timescale 1ns/10ps
module hfc_os_model (
    // clock
    input wire logic  mclk,
    // control levels
    output logic [1:0] global_round_control,
    output logic       inv_mask,
    output logic       den_mask,
    output logic       simd_handler_present,
    output logic       coproc_emulation_bit,
    output logic       os_ext_state_flag,
    output logic       vec_supported,
    output logic       cipher_supported,
    output logic       clmul_supported
);
    logic [9:0] ctl_r = 10'h0ef;
    assign {global_round_control, inv_mask, den_mask, simd_handler_present, coproc_emulation_bit,
            os_ext_state_flag, vec_supported, cipher_supported, clmul_supported} = ctl_r;
    // levels move just after an edge, as a control register write would
    task set_ctl(input logic [9:0] v);
        @(posedge mclk);
        ctl_r <= v;
    endtask : set_ctl
endmodule : hfc_os_model

// ---- test/testbench.sv ----
// self-checking bench for the half/single convert unit
`timescale 1ns/10ps
module testbench;
    import hfc_pkg::*;
    localparam int LANES = 2;
    logic mclk = 0, sys_rst = 1, op_valid = 0, xwr_valid = 0, xwr_priv = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    hfc_op_type op_code = HFC_OP_NONE;
    logic [7:0] op_imm = 0, paddr = 0;
    logic [31:0] op_ecx = 0, xwr_ecx = 0, pwdata = 0, prdata, feature_ecx, src_half = 0, res_half, rd;
    logic [63:0] src_single = 0, xwr_data = 0, res_single, res_edx_eax;
    logic [1:0] global_round_control;
    logic inv_mask, den_mask, simd_handler_present, coproc_emulation_bit, os_ext_state_flag;
    logic vec_supported, cipher_supported, clmul_supported, er;
    logic pready, pslverr, res_valid, undefined_opcode_fault, simd_fp_fault, xwr_fault, irq;
    int n_errors = 0;
    int checked = 0;

    hfc_os_model hfc_os_model_i (.mclk, .global_round_control, .inv_mask, .den_mask, .simd_handler_present,
        .coproc_emulation_bit, .os_ext_state_flag, .vec_supported, .cipher_supported, .clmul_supported);
    hfc_convert_unit #(.LANES(LANES)) hfc_convert_unit_i (.mclk, .sys_rst, .op_valid, .op_code, .op_imm,
        .op_ecx, .src_single, .src_half, .xwr_valid, .xwr_priv, .xwr_ecx, .xwr_data, .global_round_control,
        .inv_mask, .den_mask, .simd_handler_present, .coproc_emulation_bit, .os_ext_state_flag,
        .vec_supported, .cipher_supported, .clmul_supported, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .res_valid, .res_single, .res_half, .res_edx_eax,
        .undefined_opcode_fault, .simd_fp_fault, .xwr_fault, .feature_ecx, .irq);

    always #5 mclk = ~mclk;

    task summarize;
        $display("mismatches %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task chk(input logic [63:0] s, input logic [63:0] e, input string m);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    // one issue pulse; outputs are looked at just after the taking edge
    task op(input hfc_op_type c, input logic [7:0] imm, input logic [31:0] ecx);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_imm <= imm;
        op_ecx <= ecx;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        chk(res_valid, 1, "result pulse");
    endtask : op

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            chk(0, 1, "apb wait ran out");
            summarize();
        end
    endtask : apb

    task xw(input logic p, input logic [31:0] c, input logic [63:0] d, input logic f);
        @(posedge mclk);
        xwr_valid <= 1'b1;
        xwr_priv <= p;
        xwr_ecx <= c;
        xwr_data <= d;
        @(posedge mclk);
        xwr_valid <= 1'b0;
        #1;
        chk(xwr_fault, f, "ext write refusal");
    endtask : xw

    task t_gate;
        op(HFC_OP_S2H, 8'h00, 0);
        chk(undefined_opcode_fault, 1, "vector op with state off");
        op(HFC_OP_XREAD, 8'h00, 0);
        chk(res_edx_eax, XEN_RST, "enable reg at reset");
        op(HFC_OP_XREAD, 8'h00, 1);
        chk(undefined_opcode_fault, 1, "bad read index");
        xw(1'b0, 0, 7, 1'b1);
        xw(1'b1, 1, 7, 1'b1);
        xw(1'b1, 0, 6, 1'b1);
        xw(1'b1, 0, 7, 1'b0);
        op(HFC_OP_XREAD, 8'h00, 0);
        chk(res_edx_eax, 64'h7, "enable reg after write");
        hfc_os_model_i.set_ctl(10'h0ff);
        op(HFC_OP_S2H, 8'h00, 0);
        chk(undefined_opcode_fault, 0, "emulation bit set");
        apb(1'b0, OFS_XENLO, 0);
        chk(rd, 32'h7, "enable word on apb");
    endtask : t_gate

    task t_round;
        logic [31:0] ex [4];
        logic [1:0] m;
        ex = '{32'hbc013c01, 32'hbc013c00, 32'hbc003c01, 32'hbc003c00};
        src_single <= 64'hbf801800_3f801800;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            hfc_os_model_i.set_ctl({~m, 8'hff});
            op(HFC_OP_S2H, {5'h1f, 1'b0, m}, 0);
            chk(res_half, ex[k], "immediate rounding");
            hfc_os_model_i.set_ctl({m, 8'hff});
            op(HFC_OP_S2H, {5'h00, 1'b1, ~m}, 0);
            chk(res_half, ex[k], "global rounding");
        end
        hfc_os_model_i.set_ctl(10'h0ff);
    endtask : t_round

    task t_nan;
        src_single <= 64'hff812345_7fc12345;
        op(HFC_OP_S2H, 8'h00, 0);
        chk(res_half, 32'hfe097e09, "nan narrowing");
        chk(undefined_opcode_fault | simd_fp_fault, 0, "masked invalid");
        apb(1'b0, OFS_STAT, 0);
        chk(rd[FLG_INV], 1, "invalid status");
        src_single <= 64'hff812345_3f800000;
        hfc_os_model_i.set_ctl(10'h07f);
        op(HFC_OP_S2H, 8'h00, 0);
        chk(simd_fp_fault, 1, "unmasked with handler");
        chk(res_half, 32'hfe097e09, "faulted op keeps result");
        hfc_os_model_i.set_ctl(10'h05f);
        op(HFC_OP_S2H, 8'h00, 0);
        chk(undefined_opcode_fault, 1, "unmasked without handler");
        src_single <= 64'h7fc00000_7fc12345;
        op(HFC_OP_S2H, 8'h00, 0);
        chk(res_half, 32'h7e007e09, "quiet nan");
        chk(undefined_opcode_fault | simd_fp_fault, 0, "quiet nan no fault");
        apb(1'b1, OFS_STAT, 32'h3);
        hfc_os_model_i.set_ctl(10'h0ff);
    endtask : t_nan

    task t_den;
        src_single <= 64'h3f800000_00000001;
        op(HFC_OP_S2H, 8'h00, 0);
        chk(res_half, 32'h3c000000, "denormal source");
        apb(1'b0, OFS_STAT, 0);
        chk(rd[FLG_DEN], 1, "denormal status");
        apb(1'b1, OFS_STAT, 32'h3);
        src_half <= 32'hc000_0001;
        for (int k = 0; k < 2; k++) begin
            hfc_os_model_i.set_ctl(k ? 10'h0bf : 10'h0ff);
            op(HFC_OP_H2S, 8'h00, 0);
            chk(res_single, 64'hc0000000_33800000, "half to single");
            chk(undefined_opcode_fault | simd_fp_fault, 0, "half source no fault");
        end
        apb(1'b0, OFS_STAT, 0);
        chk(rd, 0, "denormal flag untouched");
        hfc_os_model_i.set_ctl(10'h0ff);
    endtask : t_den

    task t_feat;
        logic [31:0] e;
        logic [3:0] v;
        for (int k = 0; k < 2; k++) begin
            v = k ? 4'h5 : 4'ha;
            e = '0;
            e[FQ_OSXS_BIT] = v[3];
            e[FQ_VEC_BIT] = v[2];
            e[FQ_CIPHER_BIT] = v[1];
            e[FQ_CLMUL_BIT] = v[0];
            hfc_os_model_i.set_ctl({6'h0f, v});
            apb(1'b0, OFS_FEAT, 0);
            chk(rd, e, "feature word");
            chk(feature_ecx, e, "feature port");
            op(HFC_OP_XREAD, 8'h00, 0);
            chk(undefined_opcode_fault, !v[3], "read gated by os flag");
        end
        apb(1'b0, 8'h20, 0);
        chk(er, 1, "unmapped address");
        apb(1'b0, OFS_CTRL, 0);
        chk(rd, 0, "reserved word");
        hfc_os_model_i.set_ctl(10'h0ff);
    endtask : t_feat

    task t_irq;
        logic a;
        src_single <= 64'h3f800000_7f812345;
        op(HFC_OP_S2H, 8'h00, 0);
        apb(1'b1, OFS_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        a = irq;
        apb(1'b1, OFS_MASK, 32'h3);
        repeat (2) @(posedge mclk);
        chk(a ^ irq, 1, "mask gates interrupt");
        apb(1'b1, OFS_STAT, 32'h3);
        repeat (2) @(posedge mclk);
        chk(irq, 0, "clear drops interrupt");
        apb(1'b0, OFS_STAT, 0);
        chk(rd, 0, "status after clear");
    endtask : t_irq

    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_gate();
        t_round();
        t_nan();
        t_den();
        t_feat();
        t_irq();
        summarize();
    end
endmodule : testbench
